// ### src/hbc_params.svh
`ifndef HBC_PARAMS_SVH
`define HBC_PARAMS_SVH
`define HBC_CLK_MHZ 250
// Times in their own units
`define HBC_GAP_NS 200
`define HBC_GLITCH_NS 100
`define HBC_OFF_US 25
`define HBC_BLANK_US 2
`define HBC_OCD_NS 1500
`define HBC_RETRY_US 3000
`define HBC_SLEEP_US 1000
`define HBC_WAKE_US 250
// Cycle counts
`define HBC_GAP_CYC ((`HBC_GAP_NS * `HBC_CLK_MHZ + 999) / 1000)
`define HBC_GLITCH_CYC ((`HBC_GLITCH_NS * `HBC_CLK_MHZ + 999) / 1000)
`define HBC_OFF_CYC (`HBC_OFF_US * `HBC_CLK_MHZ)
`define HBC_BLANK_CYC (`HBC_BLANK_US * `HBC_CLK_MHZ)
`define HBC_OCD_CYC ((`HBC_OCD_NS * `HBC_CLK_MHZ + 999) / 1000)
`define HBC_RETRY_CYC (`HBC_RETRY_US * `HBC_CLK_MHZ)
`define HBC_SLEEP_CYC (`HBC_SLEEP_US * `HBC_CLK_MHZ)
`define HBC_WAKE_CYC (`HBC_WAKE_US * `HBC_CLK_MHZ)
`define HBC_CNT_W 20
`endif

// ### src/hbc_pkg.sv
package hbc_pkg;
    // One half-bridge leg: high-side and low-side switch enables
    typedef struct packed {
        logic hs;
        logic ls;
    } hbc_leg_s;
    typedef enum logic [1:0] {
        HBC_LV_Z,
        HBC_LV_HI,
        HBC_LV_LO
    } hbc_lvl_e;
    typedef enum logic [1:0] {
        HBC_M_SLEEP,
        HBC_M_WAKE,
        HBC_M_ACTIVE,
        HBC_M_FAULT
    } hbc_mode_e;
endpackage : hbc_pkg

// ### src/hbc_bridge.sv
`timescale 1ns/10ps
`include "hbc_params.svh"
// How it works
// - Inputs decode to coast, reverse, forward
// - Both inputs high brakes on low sides
// - Coast held about 1 ms enters sleep
// - Output passes high impedance between high, low
// - Control inputs deglitched before decoding
// - Trip when ten times sense reaches reference
// - Trip forces both low sides for off-time
// - After off-time follow commanded input state
// - Persistent switch current limit disables bridge
// - Retry after period, repeat while fault remains
// - High and low side overcurrent share one persistence timer
// - Sense overcurrent threshold also trips shutdown
// - Overtemperature disables bridge, auto resumes
// - Supply low lockout resets all logic
// - Active needs supply, input high, wake elapsed
// - Coast for sleep time enters sleep
// - Power up with inputs low goes sleep
// - Input high beyond wake time wakes device
// - Fault keeps bridge off, recovers automatically
// - Off-time is 25 us
// - Trip ignored during 2 us blanking
// - Retry period is 3 ms
// - Sleep entry between 0.8 and 1.5 ms
module hbc_bridge import hbc_pkg::*; #(
    parameter int SLEEP_CYC = `HBC_SLEEP_CYC, // Sleep delay
    parameter int WAKE_CYC = `HBC_WAKE_CYC, // Wake delay
    parameter int RETRY_CYC = `HBC_RETRY_CYC, // Retry period
    parameter int OFF_CYC = `HBC_OFF_CYC // Chop off-time
) (
    input wire logic clk, // 250 MHz clock
    input wire logic nrst, // Sync reset, supply low lockout
    input wire logic control_input_a, // Control input A
    input wire logic control_input_b, // Control input B
    input wire logic trip_cmp, // Ten times sense reached reference
    input wire logic sense_ocp, // Sense pin over threshold
    input wire logic ilim_hs_a, // High-side A current limit
    input wire logic ilim_ls_a, // Low-side A current limit
    input wire logic ilim_hs_b, // High-side B current limit
    input wire logic ilim_ls_b, // Low-side B current limit
    input wire logic overtemp, // Hot with hysteresis applied
    output hbc_leg_s bridge_output_a, // Leg A switch enables
    output hbc_leg_s bridge_output_b, // Leg B switch enables
    output logic circuits_on, // Internal circuits enabled
    output hbc_mode_e mode // Functional mode
);
    localparam int CW = `HBC_CNT_W;
    localparam logic [CW-1:0] GLITCH_N = CW'(`HBC_GLITCH_CYC);
    localparam logic [CW-1:0] GAP_N = CW'(`HBC_GAP_CYC);
    localparam logic [CW-1:0] BLANK_N = CW'(`HBC_BLANK_CYC);
    localparam logic [CW-1:0] OCD_N = CW'(`HBC_OCD_CYC);
    localparam logic [CW-1:0] SLEEP_N = CW'(SLEEP_CYC);
    localparam logic [CW-1:0] WAKE_N = CW'(WAKE_CYC);
    localparam logic [CW-1:0] RETRY_N = CW'(RETRY_CYC);
    localparam logic [CW-1:0] OFF_N = CW'(OFF_CYC);
    localparam logic [CW-1:0] ONE = CW'(1);

    // Input deglitch
    logic [1:0] raw_in;
    logic [1:0] flt_r;
    logic [CW-1:0] glt_cnt_r;
    assign raw_in = {control_input_a, control_input_b};
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flt_r <= 2'b00;
            glt_cnt_r <= '0;
        end else if (raw_in == flt_r) begin
            glt_cnt_r <= '0;
        end else if (glt_cnt_r >= GLITCH_N - ONE) begin
            flt_r <= raw_in;
            glt_cnt_r <= '0;
        end else begin
            glt_cnt_r <= glt_cnt_r + ONE;
        end
    end
    wire in_a = flt_r[1];
    wire in_b = flt_r[0];
    wire coast_cmd = !in_a && !in_b;

    // Mode sequencing
    hbc_mode_e mode_r;
    logic [CW-1:0] mode_cnt_r;
    logic [CW-1:0] retry_cnt_r;
    logic [CW-1:0] ocd_cnt_r;
    logic ocp_hold_r;
    wire ilim_any = ilim_hs_a || ilim_ls_a ||
        ilim_hs_b || ilim_ls_b;
    wire ocd_done = (ilim_any || sense_ocp) &&
        ocd_cnt_r >= OCD_N - ONE;
    wire retry_done = ocp_hold_r &&
        retry_cnt_r >= RETRY_N - ONE;
    wire fault_now = overtemp || ocp_hold_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ocd_cnt_r <= '0;
            ocp_hold_r <= 1'b0;
            retry_cnt_r <= '0;
        end else begin
            if (!(ilim_any || sense_ocp) || ocp_hold_r) begin
                ocd_cnt_r <= '0;
            end else begin
                ocd_cnt_r <= ocd_cnt_r + ONE;
            end
            if (retry_done) begin
                ocp_hold_r <= 1'b0;
                retry_cnt_r <= '0;
            end else if (ocd_done && mode_r == HBC_M_ACTIVE) begin
                ocp_hold_r <= 1'b1;
                retry_cnt_r <= '0;
            end else if (ocp_hold_r) begin
                retry_cnt_r <= retry_cnt_r + ONE;
            end
        end
    end

    // Reset starts in sleep so low inputs never pass through active
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_r <= HBC_M_SLEEP;
            mode_cnt_r <= '0;
        end else begin
            case (mode_r)
                HBC_M_SLEEP: begin
                    mode_cnt_r <= '0;
                    if (!coast_cmd) begin
                        mode_r <= HBC_M_WAKE;
                    end
                end
                HBC_M_WAKE: begin
                    if (coast_cmd) begin
                        mode_r <= HBC_M_SLEEP;
                        mode_cnt_r <= '0;
                    end else if (mode_cnt_r >= WAKE_N - ONE) begin
                        mode_r <= HBC_M_ACTIVE;
                        mode_cnt_r <= '0;
                    end else begin
                        mode_cnt_r <= mode_cnt_r + ONE;
                    end
                end
                HBC_M_ACTIVE: begin
                    if (fault_now || (ocd_done && !ocp_hold_r)) begin
                        mode_r <= HBC_M_FAULT;
                        mode_cnt_r <= '0;
                    end else if (!coast_cmd) begin
                        mode_cnt_r <= '0;
                    end else if (mode_cnt_r >= SLEEP_N - ONE) begin
                        mode_r <= HBC_M_SLEEP;
                        mode_cnt_r <= '0;
                    end else begin
                        mode_cnt_r <= mode_cnt_r + ONE;
                    end
                end
                default: begin
                    mode_cnt_r <= '0;
                    if (!fault_now && !ocd_done) begin
                        mode_r <= HBC_M_ACTIVE;
                    end
                end
            endcase
        end
    end

    // Current chopping
    logic [CW-1:0] off_cnt_r;
    logic [CW-1:0] blank_cnt_r;
    logic chop_r;
    wire drive_cmd = in_a ^ in_b;
    wire run = mode_r == HBC_M_ACTIVE;
    logic drive_d_r;
    wire drive_start = run && drive_cmd && !chop_r && !drive_d_r;
    wire blanked = blank_cnt_r != '0;
    // Blanking also covers the drive-start cycle, before the counter loads
    wire blank_win = drive_start || blanked;
    wire trip = run && drive_cmd && !chop_r && !blank_win &&
        trip_cmp;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            chop_r <= 1'b0;
            off_cnt_r <= '0;
            blank_cnt_r <= '0;
            drive_d_r <= 1'b0;
        end else begin
            drive_d_r <= run && drive_cmd && !chop_r;
            if (drive_start) begin
                blank_cnt_r <= BLANK_N;
            end else if (blanked) begin
                blank_cnt_r <= blank_cnt_r - ONE;
            end
            if (!run) begin
                chop_r <= 1'b0;
                off_cnt_r <= '0;
            end else if (trip) begin
                chop_r <= 1'b1;
                off_cnt_r <= '0;
            end else if (chop_r && off_cnt_r >= OFF_N - ONE) begin
                chop_r <= 1'b0;
                off_cnt_r <= '0;
            end else if (chop_r) begin
                off_cnt_r <= off_cnt_r + ONE;
            end
        end
    end

    // Target levels for each leg
    hbc_lvl_e want_a;
    hbc_lvl_e want_b;
    assign want_a = !run ? HBC_LV_Z : chop_r ? HBC_LV_LO :
        coast_cmd ? HBC_LV_Z : (in_a && !in_b) ? HBC_LV_HI :
        HBC_LV_LO;
    assign want_b = !run ? HBC_LV_Z : chop_r ? HBC_LV_LO :
        coast_cmd ? HBC_LV_Z : (in_b && !in_a) ? HBC_LV_HI :
        HBC_LV_LO;

    // Dead-time gap per leg
    hbc_lvl_e lv_r [2];
    logic [CW-1:0] gap_r [2];
    hbc_lvl_e want [2];
    assign want[0] = want_a;
    assign want[1] = want_b;
    for (genvar i = 0; i < 2; i++) begin : g_leg
        wire flip = (lv_r[i] == HBC_LV_HI && want[i] == HBC_LV_LO) ||
            (lv_r[i] == HBC_LV_LO && want[i] == HBC_LV_HI);
        always_ff @(posedge clk) begin
            if (!nrst) begin
                lv_r[i] <= HBC_LV_Z;
                gap_r[i] <= '0;
            end else if (gap_r[i] != '0) begin
                gap_r[i] <= gap_r[i] - ONE;
                lv_r[i] <= HBC_LV_Z;
                if (want[i] == HBC_LV_Z) begin
                    gap_r[i] <= '0;
                end else if (gap_r[i] == ONE) begin
                    lv_r[i] <= want[i];
                end
            end else if (flip) begin
                lv_r[i] <= HBC_LV_Z;
                gap_r[i] <= GAP_N;
            end else begin
                lv_r[i] <= want[i];
            end
        end
    end

    assign bridge_output_a = '{hs: lv_r[0] == HBC_LV_HI,
        ls: lv_r[0] == HBC_LV_LO};
    assign bridge_output_b = '{hs: lv_r[1] == HBC_LV_HI,
        ls: lv_r[1] == HBC_LV_LO};
    assign mode = mode_r;
    assign circuits_on = mode_r != HBC_M_SLEEP;

    property p_no_shoot;
        @(posedge clk) disable iff (!nrst)
        !(bridge_output_a.hs && bridge_output_a.ls) &&
        !(bridge_output_b.hs && bridge_output_b.ls);
    endproperty
    a_no_shoot: assert property (p_no_shoot)
        else $error("Both switches of a leg on");
    property p_gap;
        @(posedge clk) disable iff (!nrst)
        $past(lv_r[0]) == HBC_LV_HI |-> lv_r[0] != HBC_LV_LO;
    endproperty
    a_gap: assert property (p_gap)
        else $error("Leg A went high to low without gap");
    property p_fault_off;
        @(posedge clk) disable iff (!nrst)
        mode_r == HBC_M_FAULT |=> !bridge_output_a.hs && !bridge_output_b.hs;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("High side on in fault");
    property p_trip_chop;
        @(posedge clk) disable iff (!nrst)
        trip |=> chop_r;
    endproperty
    a_trip_chop: assert property (p_trip_chop)
        else $error("Trip did not start off-time");
    property p_blank;
        @(posedge clk) disable iff (!nrst)
        drive_start |-> (!trip) [*3];
    endproperty
    a_blank: assert property (p_blank)
        else $error("Trip taken during blanking");
    property p_ocp;
        @(posedge clk) disable iff (!nrst)
        ocd_done && run |=> mode_r == HBC_M_FAULT;
    endproperty
    a_ocp: assert property (p_ocp)
        else $error("Overcurrent did not shut down");
    property p_hot;
        @(posedge clk) disable iff (!nrst)
        overtemp && run |=> mode_r == HBC_M_FAULT;
    endproperty
    a_hot: assert property (p_hot)
        else $error("Overtemperature did not shut down");
    property p_sleep_z;
        @(posedge clk) disable iff (!nrst)
        mode_r == HBC_M_SLEEP |=> ##1 lv_r[0] == HBC_LV_Z;
    endproperty
    a_sleep_z: assert property (p_sleep_z)
        else $error("Output driven in sleep");
    property p_wake;
        @(posedge clk) disable iff (!nrst)
        $rose(mode_r == HBC_M_ACTIVE) && $past(mode_r) == HBC_M_WAKE
            |-> !$past(coast_cmd) && $past(mode_cnt_r) >= WAKE_N - ONE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Active entered with coast command");
endmodule : hbc_bridge

// ### dv/hbc_host.sv
`timescale 1ns/10ps
module hbc_host (
    input wire logic clk, // Bench clock
    input wire logic [1:0] want, // Requested input pair, A then B
    output logic control_input_a, // Control input A
    output logic control_input_b // Control input B
);
    initial control_input_a = 1'b0;
    initial control_input_b = 1'b0;
    // Levels move just after an edge and hold until the next request
    always @(posedge clk) begin
        {control_input_a, control_input_b} <= #1 want;
    end
endmodule : hbc_host

// ### dv/tb_hbc_bridge.sv
`timescale 1ns/10ps
`include "hbc_params.svh"
module tb_hbc_bridge import hbc_pkg::*;;
    localparam int SLP = 200;
    localparam int WK = 100;
    localparam int RT = 300;
    localparam int OF = 60;
    localparam int GP = `HBC_GAP_CYC;
    logic clk, nrst, trip_cmp, sense_ocp, overtemp, in_a, in_b, con;
    logic [3:0] ilim;
    logic [1:0] want;
    hbc_leg_s oa, ob;
    hbc_mode_e mode;
    hbc_leg_s lst [2];
    int zc [2];
    int err_total = 0;
    int checked = 0;
    hbc_host host (.clk(clk), .want(want), .control_input_a(in_a),
        .control_input_b(in_b));
    hbc_bridge #(.SLEEP_CYC(SLP), .WAKE_CYC(WK), .RETRY_CYC(RT),
        .OFF_CYC(OF)) DUT (.clk(clk), .nrst(nrst), .control_input_a(in_a),
        .control_input_b(in_b), .trip_cmp(trip_cmp), .sense_ocp(sense_ocp),
        .ilim_hs_a(ilim[0]), .ilim_ls_a(ilim[1]), .ilim_hs_b(ilim[2]),
        .ilim_ls_b(ilim[3]), .overtemp(overtemp), .bridge_output_a(oa),
        .bridge_output_b(ob), .circuits_on(con), .mode(mode));
    task automatic bad(input string s);
        err_total++;
        $display("Error at %0t: %s", $time, s);
    endtask : bad
    task automatic go(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : go
    function automatic logic [6:0] ex(input logic [1:0] p, hbc_mode_e m);
        hbc_leg_s a, b;
        a = (p == 2'b10) ? 2'b10 : (p == 2'b00) ? 2'b00 : 2'b01;
        b = (p == 2'b01) ? 2'b10 : (p == 2'b00) ? 2'b00 : 2'b01;
        return {a, b, m, m != HBC_M_SLEEP};
    endfunction : ex
    task automatic chk(input logic [6:0] e, input string s);
        checked++;
        if ({oa, ob, mode, con} !== e) begin
            bad($sformatf("%s got %b", s, {oa, ob, mode, con}));
        end
    endtask : chk
    task automatic waitm(input hbc_mode_e m, input int n);
        for (int i = 0; i < n && mode !== m; i++) go(1);
        checked++;
        if (mode !== m) begin
            bad($sformatf("mode %0d not reached", m));
        end
    endtask : waitm
    task automatic cnt(input int k, output int c);
        // k 0: wait while leg A drives high, k 1: until it does
        for (c = 0; c < 1000 && ((oa === 2'b10) == (k == 0)); c++) go(1);
    endtask : cnt
    task automatic put(input int k, input logic v);
        if (k < 4) ilim[k] = v;
        else sense_ocp = v;
    endtask : put
    task automatic fin(input string s);
        $display("Test %s done", s);
    endtask : fin
    task automatic complete_run;
        $display("Checks %0d, errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // A leg that swaps high and low must idle long enough in between
    always @(negedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if ((i ? ob : oa) === 2'b11) bad("shoot-through");
            if ((i ? ob : oa) === 2'b00) zc[i] <= zc[i] + 1;
            else begin
                if ((i ? ob : oa) !== lst[i] && lst[i] !== 2'b00 &&
                    zc[i] < GP) bad("dead time short");
                lst[i] <= i ? ob : oa;
                zc[i] <= 0;
            end
        end
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #160000;
        bad("watchdog");
        complete_run;
    end
    initial begin
        int k, c, d;
        lst[0] = 2'b00;
        lst[1] = 2'b00;
        zc = '{0, 0};
        {nrst, want, trip_cmp, sense_ocp, overtemp, ilim} = '0;
        k = $urandom(32'h8556_5172);
        go(16);
        nrst = 1'b1;
        go(40);
        chk(ex(2'b00, HBC_M_SLEEP), "power-up");
        want = 2'b10;
        go(10);
        want = 2'b00;
        go(60);
        chk(ex(2'b00, HBC_M_SLEEP), "glitch");
        want = 2'b10;
        waitm(HBC_M_WAKE, 40);
        go(WK - 30);
        chk(ex(2'b00, HBC_M_WAKE), "waking");
        waitm(HBC_M_ACTIVE, 50);
        go(5);
        chk(ex(2'b10, HBC_M_ACTIVE), "forward");
        fin("wake");
        for (k = 0; k < 12; k++) begin
            want = (k == 0) ? 2'b01 : 2'($urandom_range(3, 1));
            go(`HBC_GLITCH_CYC + GP + 20);
            chk(ex(want, HBC_M_ACTIVE), "decode");
        end
        fin("decode");
        want = 2'b11;
        go(100);
        trip_cmp = 1'b1;
        want = 2'b10;
        cnt(1, c);
        cnt(0, c);
        checked++;
        if (c < `HBC_BLANK_CYC - GP - 10 ||
            c > `HBC_BLANK_CYC + 5) begin
            bad("blanking length");
        end
        trip_cmp = 1'b0;
        go(GP + 2);
        chk(ex(2'b11, HBC_M_ACTIVE), "chop");
        cnt(1, d);
        checked++;
        if (d + GP + 2 < OF || d + GP + 2 > OF + GP + 5) begin
            bad("off-time length");
        end
        fin("chop");
        for (k = 0; k < 5; k++) begin
            put(k, 1'b1);
            go(`HBC_OCD_CYC - 40);
            put(k, 1'b0);
            go(10);
            chk(ex(2'b10, HBC_M_ACTIVE), "short limit");
            put(k, 1'b1);
            waitm(HBC_M_FAULT, `HBC_OCD_CYC + 20);
            go(5);
            chk(ex(2'b00, HBC_M_FAULT), "overcurrent");
            if (k == 0) begin
                waitm(HBC_M_ACTIVE, RT + 60);
                waitm(HBC_M_FAULT, `HBC_OCD_CYC + 20);
            end
            put(k, 1'b0);
            go(RT - 30);
            chk(ex(2'b00, HBC_M_FAULT), "retry wait");
            waitm(HBC_M_ACTIVE, 60);
        end
        fin("overcurrent");
        overtemp = 1'b1;
        waitm(HBC_M_FAULT, 20);
        go(2);
        chk(ex(2'b00, HBC_M_FAULT), "overtemp");
        overtemp = 1'b0;
        waitm(HBC_M_ACTIVE, 20);
        fin("thermal");
        want = 2'b00;
        go(SLP - 20);
        chk(ex(2'b00, HBC_M_ACTIVE), "coast");
        waitm(HBC_M_SLEEP, 80);
        chk(ex(2'b00, HBC_M_SLEEP), "asleep");
        fin("sleep");
        want = 2'b10;
        waitm(HBC_M_WAKE, 40);
        want = 2'b00;
        waitm(HBC_M_SLEEP, 40);
        chk(ex(2'b00, HBC_M_SLEEP), "wake abort");
        want = 2'b01;
        waitm(HBC_M_ACTIVE, WK + 60);
        go(80);
        nrst = 1'b0;
        go(2);
        chk(ex(2'b00, HBC_M_SLEEP), "lockout");
        go(14);
        nrst = 1'b1;
        waitm(HBC_M_ACTIVE, WK + 60);
        go(5);
        chk(ex(2'b01, HBC_M_ACTIVE), "after lockout");
        fin("lockout");
        complete_run;
    end
endmodule : tb_hbc_bridge
